/* include/lbp_pkg.sv */
/*
 * shared constants for the local bus pin controller: widths, pattern word
 * layout, machine and nand step encodings, clock ratio codes, idle levels.
 * assumes nothing beyond a systemverilog compiler.
 */
package lbp_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int MUX_W = 16;
  localparam int PLAIN_W = 10;
  localparam int ADDR_W = 26;
  localparam int SRC_W = 5;
  localparam int GPL_W = 6;
  localparam int LANES = 2;

  localparam logic [SRC_W-1:0] SRC_IDLE = 5'h1f;
  localparam logic [GPL_W-1:0] GPL_IDLE = 6'h3f;

  // pattern array word: six lines, two lanes, wait honour, last word
  localparam int PAT_DEPTH = 64;
  localparam int PAT_AW = 6;
  localparam int PAT_W = 10;
  localparam int PAT_GPL_LSB = 0;
  localparam int PAT_LANE_LSB = 6;
  localparam int PAT_WAIT_BIT = 8;
  localparam int PAT_LAST_BIT = 9;

  // user pattern line positions reused by the other machines
  localparam int GPL_CMD_LATCH = 0;
  localparam int GPL_ADDR_LATCH = 1;
  localparam int GPL_READ_STROBE = 2;
  localparam int GPL_PROTECT = 3;
  localparam int GPL_TERM = 4;

  localparam logic [1:0] MACH_CHIP_SELECT = 2'h0;
  localparam logic [1:0] MACH_NAND = 2'h1;
  localparam logic [1:0] MACH_PATTERN = 2'h2;

  localparam logic [1:0] NAND_CMD = 2'h0;
  localparam logic [1:0] NAND_ADDR = 2'h1;
  localparam logic [1:0] NAND_WDATA = 2'h2;
  localparam logic [1:0] NAND_RDATA = 2'h3;

  localparam logic [1:0] RATIO_2 = 2'h0;
  localparam logic [1:0] RATIO_4 = 2'h1;
  localparam logic [1:0] RATIO_8 = 2'h2;

  localparam int DIV_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CS_DATA_CYCLES = 4'h2;
  localparam logic [CNT_W-1:0] NAND_DATA_CYCLES = 4'h2;
  localparam logic BUS_DIR_RESET = 1'b1;

  typedef enum logic [1:0] {LBP_IDLE, LBP_LATCH, LBP_DATA, LBP_FINISH} lbp_state_t;
endpackage

/* include/lbp_pat_if.sv */
/*
 * carrier between the controller and its pattern array memory.
 * assumes lbp_pkg is compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
interface lbp_pat_if;
  logic wr_en;
  logic [lbp_pkg::PAT_AW-1:0] wr_addr;
  logic [lbp_pkg::PAT_W-1:0] wr_data;
  logic [lbp_pkg::PAT_AW-1:0] rd_addr;
  logic [lbp_pkg::PAT_W-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

/* rtl/lbp_pattern_mem.sv */
/*
 * pattern array storage: one write port, registered read data.
 * assumes a single clock shared with the controller.
 */
`timescale 1ns/1ns
`default_nettype none
module lbp_pattern_mem (
  input wire logic i_clk,
  input wire logic i_rst_b,
  lbp_pat_if.mem pat
);
  import lbp_pkg::*;

  logic [PAT_W-1:0] mem_reg [PAT_DEPTH];

  always_ff @(posedge i_clk) begin
    if (pat.wr_en) begin
      mem_reg[pat.wr_addr] <= pat.wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pat.rd_data <= '0;
    end else begin
      pat.rd_data <= mem_reg[pat.rd_addr];
    end
  end
endmodule
`default_nettype wire

/* rtl/lbp_local_bus_pin.sv */
/*
 * local bus pin controller: address latch phase, bank selects and the
 * strobes of the chip select, nand and pattern machines, bus clock divider,
 * buffer direction and debug source id / data valid.
 * assumes configuration inputs are steady while a transfer runs and that
 * pins are wired outside; two-way pins come as in/out/enable triples.
 */
//
// Contract
// RQ1: latch strobe asserts with address on muxed bus at every transfer start.
// RQ2: latch length follows bank extra delay option and latch cycle count.
// RQ3: while latch strobe is high all other controls stay negated.
// RQ4: four active-low bank selects, never more than one low.
// RQ5: bank select n serves bank n with that bank's settings.
// RQ6: 8-bit port uses lane 0 only; low address bits pick valid lanes; code takes 16-bit lanes from i_req_byte_en instead.
// RQ7: chip select machine strobes only the lanes enabled for writing.
// RQ8: nand machine raises cmd/addr latch lines, write strobe for writes.
// RQ9: nand machine pulses read strobe for each data read.
// RQ10: pattern machine drives six lines and two lanes from array word.
// RQ11: chip select machine enables memory output buffer on reads.
// RQ12: nand machine drives protect low when protect mode is set.
// RQ13: termination pin is ack in chip select, output or wait in pattern.
// RQ14: nand machine stalls while ready/busy is low, resumes when high; code stalls only the write and read data steps, not cmd or addr.
// RQ15: buffer direction driven on bank access unless bank disables it.
// RQ16: buffer direction high after reset and in address phases.
// RQ17: plain address fully used for 8-bit, lowest bit don't-care for 16-bit.
// RQ18: muxed bits 7:0 carry offset 0 byte, 15:8 offset 1 byte.
// RQ19: after latch drive write data or release; release after last write.
// RQ20: outside latch passes address while strobe high, holds on negation.
// RQ21: debug data valid pulses one bus cycle per beat at data end.
// RQ22: data valid only in debug mode, marks each transfer acknowledge.
// RQ23: source id all high except last latch cycle or during data valid.
// RQ24: both bus clock outputs carry the identical waveform.
// RQ25: source id 0x1f means no valid address or data.
// RQ26: bus clock is system clock divided by 2, 4 or 8.
`timescale 1ns/1ns
`default_nettype none
module lbp_local_bus_pin #(
  parameter int NBANK = lbp_pkg::NUM_BANKS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_clk_ratio_ctrl,
  input wire logic [1:0] i_latch_cycle_count,
  input wire logic i_debug_mode,
  input wire logic i_nand_protect_en,
  input wire logic i_pat_term_wait,
  input wire logic [NBANK*2-1:0] i_bank_machine,
  input wire logic [NBANK-1:0] i_bank_port16,
  input wire logic [NBANK-1:0] i_extra_latch_delay,
  input wire logic [NBANK-1:0] i_buffer_ctrl_disable,
  input wire logic [NBANK-1:0] i_bank_ext_ack,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [lbp_pkg::BANK_W-1:0] i_req_bank,
  input wire logic [lbp_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [lbp_pkg::MUX_W-1:0] i_req_wdata,
  input wire logic [lbp_pkg::LANES-1:0] i_req_byte_en,
  input wire logic [1:0] i_req_nand_step,
  input wire logic [lbp_pkg::PAT_AW-1:0] i_req_pat_start,
  input wire logic [lbp_pkg::SRC_W-1:0] i_req_src_id,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [lbp_pkg::MUX_W-1:0] o_rsp_rdata,
  input wire logic i_pat_wr_en,
  input wire logic [lbp_pkg::PAT_AW-1:0] i_pat_wr_addr,
  input wire logic [lbp_pkg::PAT_W-1:0] i_pat_wr_data,
  output logic o_addr_latch_strobe,
  output logic [NBANK-1:0] o_bank_select_n,
  output logic [lbp_pkg::LANES-1:0] o_byte_write_strobe_n,
  output logic [lbp_pkg::GPL_W-1:0] o_user_pattern_line,
  input wire logic i_term_pin,
  output logic o_term_pin_oe,
  output logic o_buffer_direction,
  output logic [lbp_pkg::PLAIN_W-1:0] o_plain_addr_bus,
  input wire logic [lbp_pkg::MUX_W-1:0] i_muxed_addr_data,
  output logic [lbp_pkg::MUX_W-1:0] o_muxed_addr_data,
  output logic o_muxed_oe,
  output logic [1:0] o_bus_clock_out,
  output logic o_debug_data_valid,
  output logic [lbp_pkg::SRC_W-1:0] o_debug_source_id
);
  import lbp_pkg::*;

  function automatic logic [DIV_W-1:0] div_last(input logic [1:0] sel);
    logic [DIV_W-1:0] r;
    r = 3'h1;
    case (sel)
      RATIO_4: r = 3'h3;
      RATIO_8: r = 3'h7;
      default: r = 3'h1;
    endcase
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] latch_last(input logic ead, input logic [1:0] latch_cycle_count);
    return ead ? {2'h0, latch_cycle_count} : 4'h0;
  endfunction

  lbp_pat_if pat ();

  lbp_pattern_mem u_pat (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .pat(pat.mem)
  );

  logic [DIV_W-1:0] div_reg;
  logic tick;
  lbp_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [PAT_AW-1:0] ptr_reg, ptr_next;
  logic pend_reg;
  logic take;
  logic wr_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [MUX_W-1:0] wdata_reg;
  logic [LANES-1:0] be_reg;
  logic [1:0] step_reg;
  logic [PAT_AW-1:0] start_reg;
  logic [SRC_W-1:0] src_reg;
  logic [1:0] mach_reg;
  logic port16_reg, ead_reg, buffer_ctrl_disable_reg, ack_en_reg;
  logic term_s1, term_s2;
  logic [MUX_W-1:0] mux_s1, mux_s2;
  logic data_end;
  logic beat;
  logic pat_stall;
  logic nand_stall;

  assign tick = (div_reg == div_last(i_clk_ratio_ctrl));
  assign take = i_req_valid && o_req_ready;

  // bus clock divider; both clock pins come from the same count
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= '0;
      o_bus_clock_out <= 2'h0;
    end else begin
      div_reg <= tick ? 3'h0 : div_reg + 3'h1; // RQ26
      o_bus_clock_out <= {2{div_reg > (div_last(i_clk_ratio_ctrl) >> 1)}}; // RQ24
    end
  end

  // pin inputs through two flops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      term_s1 <= 1'b1;
      term_s2 <= 1'b1;
      mux_s1 <= '0;
      mux_s2 <= '0;
    end else begin
      term_s1 <= i_term_pin;
      term_s2 <= term_s1;
      mux_s1 <= i_muxed_addr_data;
      mux_s2 <= mux_s1;
    end
  end

  // request capture with the selected bank's settings
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_reg <= 1'b0;
      wr_reg <= 1'b0;
      bank_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      be_reg <= '0;
      step_reg <= NAND_CMD;
      start_reg <= '0;
      src_reg <= SRC_IDLE;
      mach_reg <= MACH_CHIP_SELECT;
      port16_reg <= 1'b0;
      ead_reg <= 1'b0;
      buffer_ctrl_disable_reg <= 1'b0;
      ack_en_reg <= 1'b0;
    end else if (take) begin
      pend_reg <= 1'b1;
      wr_reg <= i_req_write;
      bank_reg <= i_req_bank;
      addr_reg <= i_req_addr;
      wdata_reg <= i_req_wdata;
      be_reg <= i_req_byte_en;
      step_reg <= i_req_nand_step;
      start_reg <= i_req_pat_start;
      src_reg <= i_req_src_id;
      mach_reg <= i_bank_machine[i_req_bank*2 +: 2]; // RQ5
      port16_reg <= i_bank_port16[i_req_bank];
      ead_reg <= i_extra_latch_delay[i_req_bank];
      buffer_ctrl_disable_reg <= i_buffer_ctrl_disable[i_req_bank];
      ack_en_reg <= i_bank_ext_ack[i_req_bank];
    end else if (tick && state_reg == LBP_IDLE) begin
      pend_reg <= 1'b0;
    end
  end

  assign pat_stall = i_pat_term_wait && pat.rd_data[PAT_WAIT_BIT] && term_s2; // RQ13
  assign nand_stall = (step_reg == NAND_WDATA || step_reg == NAND_RDATA) && !term_s2; // RQ14

  always_comb begin
    data_end = 1'b0;
    case (mach_reg)
      MACH_CHIP_SELECT: data_end = ack_en_reg ? !term_s2 : (cnt_reg == 4'h0); // RQ13
      MACH_NAND: data_end = (cnt_reg == 4'h0) && !nand_stall;
      MACH_PATTERN: data_end = pat.rd_data[PAT_LAST_BIT] && !pat_stall;
      default: data_end = 1'b1;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    if (tick) begin
      case (state_reg)
        LBP_IDLE: begin
          if (pend_reg) begin
            state_next = LBP_LATCH; // RQ1
            cnt_next = latch_last(ead_reg, i_latch_cycle_count); // RQ2
            ptr_next = start_reg;
          end
        end
        LBP_LATCH: begin
          if (cnt_reg == 4'h0) begin
            state_next = LBP_DATA;
            cnt_next = (mach_reg == MACH_NAND) ? NAND_DATA_CYCLES - 4'h1 : CS_DATA_CYCLES - 4'h1;
          end else begin
            cnt_next = cnt_reg - 4'h1;
          end
        end
        LBP_DATA: begin
          if (data_end) begin
            state_next = LBP_FINISH;
          end else if (mach_reg == MACH_PATTERN) begin
            if (!pat_stall) begin
              ptr_next = ptr_reg + 6'h1;
            end
          end else if (!(mach_reg == MACH_NAND && nand_stall) && cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1; // RQ14
          end
        end
        LBP_FINISH: state_next = LBP_IDLE;
        default: state_next = LBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= LBP_IDLE;
      cnt_reg <= '0;
      ptr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
    end
  end

  // pattern array: write port from the user, read follows the next pointer
  assign pat.wr_en = i_pat_wr_en;
  assign pat.wr_addr = i_pat_wr_addr;
  assign pat.wr_data = i_pat_wr_data;
  assign pat.rd_addr = ptr_next;

  // request and answer handshake
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
    end else begin
      o_req_ready <= (state_reg == LBP_IDLE) && !pend_reg && !take;
      o_rsp_valid <= tick && state_reg == LBP_DATA && data_end;
      if (tick && state_reg == LBP_DATA && data_end && !wr_reg) begin
        o_rsp_rdata <= port16_reg ? mux_s2 : {8'h00, mux_s2[7:0]}; // RQ18
      end
    end
  end

  // one beat per transfer ends in the bus cycle that acknowledges it
  assign beat = state_reg == LBP_DATA && data_end;

  // pin values, registered one clock behind the state
  logic latch_c;
  logic [NBANK-1:0] cs_n_c;
  logic [LANES-1:0] we_n_c;
  logic [LANES-1:0] lanes_c;
  logic [GPL_W-1:0] gpl_c;
  logic term_oe_c;
  logic dir_c;
  logic [MUX_W-1:0] mux_c;
  logic mux_oe_c;
  logic dval_c;
  logic [SRC_W-1:0] src_c;
  logic in_data;

  assign in_data = state_reg == LBP_DATA;

  always_comb begin
    latch_c = 1'b0;
    cs_n_c = '1;
    we_n_c = '1;
    gpl_c = GPL_IDLE;
    term_oe_c = 1'b0;
    dir_c = BUS_DIR_RESET;
    mux_c = '0;
    mux_oe_c = 1'b0;
    lanes_c = port16_reg ? be_reg : 2'h1; // RQ6
    if (state_reg == LBP_LATCH) begin
      latch_c = 1'b1; // RQ1
      mux_c = addr_reg[MUX_W-1:0];
      mux_oe_c = 1'b1;
    end else if (in_data) begin
      cs_n_c[bank_reg] = 1'b0; // RQ4
      if (wr_reg) begin
        mux_c = port16_reg ? wdata_reg : {8'h00, wdata_reg[7:0]}; // RQ18
        mux_oe_c = 1'b1; // RQ19
      end
      dir_c = wr_reg || buffer_ctrl_disable_reg; // RQ15
      case (mach_reg)
        MACH_CHIP_SELECT: begin
          if (wr_reg) begin
            we_n_c = ~lanes_c; // RQ7
          end else begin
            gpl_c[GPL_READ_STROBE] = 1'b0; // RQ11
          end
        end
        MACH_NAND: begin
          gpl_c[GPL_CMD_LATCH] = step_reg == NAND_CMD; // RQ8
          gpl_c[GPL_ADDR_LATCH] = step_reg == NAND_ADDR;
          gpl_c[GPL_PROTECT] = !i_nand_protect_en; // RQ12
          if (cnt_reg != 4'h0 && !nand_stall) begin
            we_n_c[0] = step_reg == NAND_RDATA;
            gpl_c[GPL_READ_STROBE] = step_reg != NAND_RDATA; // RQ9
          end
          if (step_reg != NAND_RDATA) begin
            mux_c = {8'h00, wdata_reg[7:0]};
            mux_oe_c = 1'b1;
          end
          dir_c = (step_reg != NAND_RDATA) || buffer_ctrl_disable_reg;
        end
        MACH_PATTERN: begin
          gpl_c = pat.rd_data[PAT_GPL_LSB +: GPL_W]; // RQ10
          we_n_c = pat.rd_data[PAT_LANE_LSB +: LANES];
          term_oe_c = !i_pat_term_wait; // RQ13
        end
        default: cs_n_c = '1;
      endcase
    end
    if (!in_data && mach_reg == MACH_NAND) begin
      gpl_c[GPL_CMD_LATCH] = 1'b0; // RQ3
      gpl_c[GPL_ADDR_LATCH] = 1'b0;
      gpl_c[GPL_PROTECT] = latch_c || !i_nand_protect_en; // RQ12
    end
  end

  always_comb begin
    dval_c = i_debug_mode && beat; // RQ22
    src_c = SRC_IDLE; // RQ25
    if (i_debug_mode) begin
      if (state_reg == LBP_LATCH && cnt_reg == 4'h0) begin
        src_c = src_reg; // RQ23
      end else if (dval_c) begin
        src_c = src_reg; // RQ23
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_addr_latch_strobe <= 1'b0;
      o_bank_select_n <= '1;
      o_byte_write_strobe_n <= '1;
      o_user_pattern_line <= GPL_IDLE;
      o_term_pin_oe <= 1'b0;
      o_buffer_direction <= BUS_DIR_RESET; // RQ16
      o_plain_addr_bus <= '0;
      o_muxed_addr_data <= '0;
      o_muxed_oe <= 1'b0;
      o_debug_data_valid <= 1'b0;
      o_debug_source_id <= SRC_IDLE;
    end else begin
      o_addr_latch_strobe <= latch_c; // RQ3
      o_bank_select_n <= latch_c ? '1 : cs_n_c; // RQ3
      o_byte_write_strobe_n <= latch_c ? '1 : we_n_c;
      o_user_pattern_line <= gpl_c;
      o_term_pin_oe <= term_oe_c;
      o_buffer_direction <= latch_c ? 1'b1 : dir_c; // RQ16
      o_plain_addr_bus <= port16_reg ? {addr_reg[ADDR_W-1:MUX_W+1], 1'b0} : addr_reg[ADDR_W-1:MUX_W]; // RQ17
      o_muxed_addr_data <= mux_c;
      o_muxed_oe <= mux_oe_c; // RQ19
      o_debug_data_valid <= dval_c; // RQ21
      o_debug_source_id <= src_c;
    end
  end
endmodule
`default_nettype wire

/* testbench/lbp_local_bus_pin_sva.sv */
/* port checker for the local bus pin controller.
   assumes it is bound into lbp_local_bus_pin and sees one clock. */
`timescale 1ns/1ns
`default_nettype none
module lbp_local_bus_pin_sva #(
  parameter int NBANK = lbp_pkg::NUM_BANKS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_clk_ratio_ctrl,
  input wire logic i_debug_mode,
  input wire logic o_addr_latch_strobe,
  input wire logic [NBANK-1:0] o_bank_select_n,
  input wire logic [lbp_pkg::LANES-1:0] o_byte_write_strobe_n,
  input wire logic o_buffer_direction,
  input wire logic o_muxed_oe,
  input wire logic o_rsp_valid,
  input wire logic [1:0] o_bus_clock_out,
  input wire logic o_debug_data_valid,
  input wire logic [lbp_pkg::SRC_W-1:0] o_debug_source_id
);
  import lbp_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_one_select: assert property ($onehot0(~o_bank_select_n))
    else $error("two bank selects low");
  a_latch_quiet: assert property (o_addr_latch_strobe |-> &o_bank_select_n && &o_byte_write_strobe_n)
    else $error("control active during latch");
  a_latch_drive: assert property (o_addr_latch_strobe |-> o_muxed_oe && o_buffer_direction)
    else $error("latch phase without address drive");
  a_clock_pair: assert property (o_bus_clock_out[0] == o_bus_clock_out[1])
    else $error("bus clocks differ");
  a_div_two: assert property ($rose(o_bus_clock_out[0]) && i_clk_ratio_ctrl == RATIO_2 |=> !o_bus_clock_out[0])
    else $error("bus clock high too long at ratio 2");
  a_div_four: assert property ($rose(o_bus_clock_out[0]) && i_clk_ratio_ctrl == RATIO_4
    |=> o_bus_clock_out[0] ##1 !o_bus_clock_out[0])
    else $error("bus clock wrong at ratio 4");
  a_div_eight: assert property ($fell(o_bus_clock_out[0]) && i_clk_ratio_ctrl == RATIO_8
    |=> !o_bus_clock_out[0] [*3] ##1 o_bus_clock_out[0])
    else $error("bus clock wrong at ratio 8");
  a_dval_once: assert property (o_debug_data_valid && !o_rsp_valid |=> o_debug_data_valid)
    else $error("data valid shorter than a bus cycle");
  a_dval_debug: assert property (!i_debug_mode |-> !o_debug_data_valid)
    else $error("data valid outside debug");
  a_srcid_idle: assert property (!o_addr_latch_strobe && !o_debug_data_valid |-> o_debug_source_id == SRC_IDLE)
    else $error("source id not idle");
  a_bus_release: assert property (o_rsp_valid |=> !o_muxed_oe)
    else $error("bus driven at transfer end");

  c_read_done: cover property (o_rsp_valid && !o_buffer_direction);
  c_dval: cover property (o_debug_data_valid);
  c_latch_end: cover property ($fell(o_addr_latch_strobe));
endmodule
`default_nettype wire

/* testbench/lbp_far_side.sv */
/* far side of the local bus: ram on banks 0 and 3, a transparent
   address latch and the nand ready/busy line.
   assumes the bench resolves the shared pins from the enables. */
`timescale 1ns/1ns
`default_nettype none
module lbp_far_side (
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic i_addr_latch_strobe,
  input wire logic [3:0] i_bank_select_n,
  input wire logic [1:0] i_byte_write_strobe_n,
  input wire logic [5:0] i_user_pattern_line,
  input wire logic i_muxed_oe,
  input wire logic [15:0] i_muxed_addr_data,
  output logic o_ready_busy,
  output logic [15:0] o_read_data
);
  logic [15:0] mem [256];
  logic [15:0] addr_reg = 16'h0;
  logic [15:0] last_reg = 16'h0;
  logic [7:0] idx;
  logic ram_sel;
  logic wr_ok;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h0;
  // passes the address while the strobe is high, holds it after
  assign idx = i_addr_latch_strobe ? i_muxed_addr_data[7:0] : addr_reg[7:0];
  assign ram_sel = !i_bank_select_n[0] || !i_bank_select_n[3];
  assign wr_ok = ram_sel && i_muxed_oe;
  assign o_ready_busy = !i_busy;
  always @(posedge i_clk) begin
    if (i_addr_latch_strobe) addr_reg <= i_muxed_addr_data;
    if (wr_ok && !i_byte_write_strobe_n[0]) mem[idx][7:0] <= i_muxed_addr_data[7:0];
    if (wr_ok && !i_byte_write_strobe_n[1]) mem[idx][15:8] <= i_muxed_addr_data[15:8];
    if (ram_sel && !i_user_pattern_line[2]) last_reg <= mem[idx];
  end
  // a released bus shows the inverse of the last value, never a stale copy
  assign o_read_data = (ram_sel && !i_user_pattern_line[2] && !i_muxed_oe) ? mem[idx] : ~last_reg;
endmodule
`default_nettype wire

/* testbench/test_local_bus_pin_interface.sv */
/* self-checking bench for the local bus pin controller.
   assumes lbp_pkg, the design, the far side model and the checker. */
`timescale 1ns/1ns
`default_nettype none
module test_local_bus_pin_interface;
  import lbp_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_debug_mode = 1, i_nand_protect_en = 0, i_pat_term_wait = 0;
  logic i_req_valid = 0, i_req_write = 0, i_pat_wr_en = 0, busy = 0;
  logic [1:0] i_clk_ratio_ctrl = 2'h0, i_latch_cycle_count = 2'h0, i_req_bank = 2'h0;
  logic [1:0] i_req_byte_en = 2'h0, i_req_nand_step = 2'h0;
  logic [7:0] i_bank_machine = 8'h24;
  logic [3:0] i_bank_port16 = 4'h9, i_extra_latch_delay = 4'h2, i_buffer_ctrl_disable = 4'h8, i_bank_ext_ack = 4'h0;
  logic [25:0] i_req_addr = 26'h0;
  logic [15:0] i_req_wdata = 16'h0;
  logic [5:0] i_req_pat_start = 6'h0, i_pat_wr_addr = 6'h0;
  logic [4:0] i_req_src_id = 5'h0;
  logic [9:0] i_pat_wr_data = 10'h0;
  logic o_req_ready, o_rsp_valid, o_addr_latch_strobe, o_term_pin_oe, o_buffer_direction, o_muxed_oe;
  logic o_debug_data_valid, i_term_pin, ready_busy;
  logic [15:0] o_rsp_rdata, o_muxed_addr_data, i_muxed_addr_data, far_data, addr_lat, rdata;
  logic [3:0] o_bank_select_n, sel_and;
  logic [1:0] o_byte_write_strobe_n, o_bus_clock_out;
  logic [5:0] o_user_pattern_line;
  logic [9:0] o_plain_addr_bus, plain_lat;
  logic [4:0] o_debug_source_id, src, src_lat, src_dv;
  logic [7:0] fl;
  logic [15:0] model [256];
  int errors = 0, samples_checked = 0, seed = 59, lat_cnt, dval_cnt, cyc;

  lbp_local_bus_pin u_lbp_local_bus_pin (.*);
  lbp_far_side u_lbp_far_side (.i_clk(i_clk), .i_busy(busy), .i_addr_latch_strobe(o_addr_latch_strobe),
    .i_bank_select_n(o_bank_select_n), .i_byte_write_strobe_n(o_byte_write_strobe_n),
    .i_user_pattern_line(o_user_pattern_line), .i_muxed_oe(o_muxed_oe), .i_muxed_addr_data(o_muxed_addr_data),
    .o_ready_busy(ready_busy), .o_read_data(far_data));
  assign i_muxed_addr_data = o_muxed_oe ? o_muxed_addr_data : far_data;
  assign i_term_pin = o_term_pin_oe ? o_user_pattern_line[GPL_TERM] : ready_busy;

  initial forever #50 i_clk = ~i_clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang();
    chk("bounded wait", 0, 1);
    end_of_test();
  endtask

  task automatic do_reset(input int r);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    i_clk_ratio_ctrl <= 2'(r);
    i_latch_cycle_count <= 2'(r + 1);
    i_extra_latch_delay <= (r == 2) ? 4'h3 : 4'h2;
    i_nand_protect_en <= r[0];
    repeat (3) @(posedge i_clk);
    chk("reset pins", {o_buffer_direction, o_bank_select_n, o_debug_source_id}, {1'b1, 4'hf, SRC_IDLE});
    i_rst_b <= 1'b1;
    i_pat_wr_en <= 1'b1;
    i_pat_wr_addr <= 6'(5 + r);
    i_pat_wr_data <= 10'h255;
    i_req_pat_start <= 6'(5 + r);
    @(posedge i_clk);
    i_pat_wr_en <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic xfer(input logic [1:0] bank, input logic wr, input logic [1:0] step, input logic [25:0] addr,
                      input logic [15:0] wd, input logic [1:0] be);
    int n;
    int lat_exp;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 200) hang();
    src = 5'($random(seed) & 15);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req_write <= wr;
    i_req_bank <= bank;
    i_req_nand_step <= step;
    i_req_addr <= addr;
    i_req_wdata <= wd;
    i_req_byte_en <= be;
    i_req_src_id <= src;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    {lat_cnt, dval_cnt, cyc, sel_and, fl} = {32'h0, 32'h0, 32'h0, 4'hf, 8'h0};
    while (o_rsp_valid !== 1'b1 && cyc < 3000) begin
      @(negedge i_clk);
      cyc++;
      sel_and &= o_bank_select_n;
      if (o_addr_latch_strobe) {lat_cnt, src_lat, addr_lat, plain_lat} =
        {lat_cnt + 1, o_debug_source_id, o_muxed_addr_data, o_plain_addr_bus};
      if (o_debug_data_valid) {dval_cnt, src_dv} = {dval_cnt + 1, o_debug_source_id};
      if (!(&o_bank_select_n)) fl |= {o_user_pattern_line[0], o_user_pattern_line[1], !o_user_pattern_line[2],
        !o_byte_write_strobe_n[0], !o_buffer_direction, !o_user_pattern_line[3],
        o_user_pattern_line == 6'h15 && o_byte_write_strobe_n == 2'h1, o_term_pin_oe};
    end
    if (cyc >= 3000) hang();
    rdata = o_rsp_rdata;
    lat_exp = (1 + (i_extra_latch_delay[bank] ? int'(i_latch_cycle_count) : 0)) * (2 << i_clk_ratio_ctrl);
    chk("bank select", sel_and, 4'(~(4'h1 << bank)));
    chk("latch cycles", lat_cnt, lat_exp);
    chk("latch address", addr_lat, addr[15:0]);
    chk("plain address", plain_lat, {addr[25:17], addr[16] & !i_bank_port16[bank]});
    chk("data valid count", dval_cnt, i_debug_mode ? 2 << i_clk_ratio_ctrl : 0);
    chk("latch source id", src_lat, i_debug_mode ? src : SRC_IDLE);
    if (i_debug_mode) chk("data source id", src_dv, src);
    $display("transfer on bank %0d done", bank);
  endtask

  initial begin
    logic [25:0] adr [4];
    logic [15:0] wd;
    logic [1:0] be;
    for (int k = 0; k < 256; k++) model[k] = 16'h0;
    for (int r = 0; r < 3; r++) begin
      do_reset(r);
      for (int i = 0; i < 4; i++) begin
        adr[i] = {10'($random(seed)), 8'h0, 8'(r * 16 + i * 2)};
        wd = 16'($random(seed));
        be = 2'($random(seed));
        xfer(i[0] ? 2'h3 : 2'h0, 1'b1, 2'h0, adr[i], wd, be);
        if (be[0]) model[adr[i][7:0]][7:0] = wd[7:0];
        if (be[1]) model[adr[i][7:0]][15:8] = wd[15:8];
      end
      for (int i = 0; i < 4; i++) begin
        xfer(i[0] ? 2'h0 : 2'h3, 1'b0, 2'h0, adr[i], 16'h0, 2'h0);
        chk("read data", rdata, model[adr[i][7:0]]);
        chk("buffer direction", fl[3], i[0]);
      end
      for (int s = 0; s < 4; s++) begin
        xfer(2'h1, s < 3, 2'(s), 26'($random(seed)), 16'($random(seed)), 2'h1);
        chk("nand lines", fl[7:4], {s == 0, s == 1, s == 3, s < 3});
        chk("nand protect", fl[2], r[0]);
      end
      xfer(2'h2, 1'b1, 2'h0, 26'($random(seed)), 16'h0, 2'h3);
      chk("pattern lines", fl[1:0], 2'h3);
    end
    @(posedge i_clk);
    i_debug_mode <= 1'b0;
    xfer(2'h0, 1'b1, 2'h0, 26'h40, 16'ha5c3, 2'h3);
    model[8'h40] = 16'ha5c3;
    busy <= 1'b1;
    fork
      xfer(2'h1, 1'b0, NAND_RDATA, 26'h0, 16'h0, 2'h0);
      begin
        repeat (120) @(posedge i_clk);
        busy <= 1'b0;
      end
    join
    chk("nand stall", cyc >= 110, 1'b1);
    xfer(2'h3, 1'b0, 2'h0, 26'h40, 16'h0, 2'h0);
    chk("read after stall", rdata, model[8'h40]);
    end_of_test();
  end
endmodule
bind lbp_local_bus_pin lbp_local_bus_pin_sva #(.NBANK(NBANK)) u_lbp_local_bus_pin_sva (.*);
`default_nettype wire
